//--- hw/pic_params.svh
// Constants for the panel inhibit and silence control block
`ifndef PIC_PARAMS_SVH
`define PIC_PARAMS_SVH

`define PIC_CLK_HZ 100000000
`define PIC_DEBOUNCE_US 10000
`define PIC_DEBOUNCE_CYCLES (`PIC_DEBOUNCE_US * (`PIC_CLK_HZ / 1000000))
`define PIC_TICK_S 1
`define PIC_TICK_CYCLES (`PIC_TICK_S * `PIC_CLK_HZ)
`define PIC_RESOUND_H 24
`define PIC_RESOUND_TICKS (`PIC_RESOUND_H * 3600 / `PIC_TICK_S)

`define PIC_ADDR_CTRL 8'h00
`define PIC_ADDR_STATUS 8'h04
`define PIC_ADDR_INT_STATUS 8'h08
`define PIC_ADDR_INT_MASK 8'h0C

`define PIC_CTRL_KEYS_EN_BIT 0
`define PIC_CTRL_RESET 1'b1
`define PIC_INT_MASK_RESET 4'h0

`define PIC_KEY_MUTE 0
`define PIC_KEY_AUX 1
`define PIC_KEY_NAC 2
`define PIC_KEY_DRILL 3

`define PIC_EV_RESOUND 0
`define PIC_EV_AUX_IGNORED 1
`define PIC_EV_DRILL_IGNORED 2
`define PIC_EV_TIMER_START 3

`define PIC_ST_MUTE 0
`define PIC_ST_AUX_INH 1
`define PIC_ST_NAC_INH 2
`define PIC_ST_DRILL 3
`define PIC_ST_TIMER 4

`endif

//--- hw/pic_pkg.sv
// Types for the panel inhibit and silence control block
package pic_pkg;
	typedef logic [19:0] pic_deb_t;
	typedef logic [26:0] pic_tick_t;
	typedef logic [16:0] pic_hold_t;

	typedef struct packed {
		logic [3:0] sync1;
		logic [3:0] sync2;
		logic [3:0] sync3;
		logic [3:0] key_level;
		logic [3:0][19:0] deb_cnt;
		logic mute;
		logic aux_inh;
		logic nac_inh;
		logic drill;
		pic_tick_t tick_cnt;
		pic_hold_t hold_cnt;
		logic timer_armed;
		logic flash;
		logic keys_en;
		logic [3:0] int_status;
		logic [3:0] int_mask;
		logic irq;
		logic sounder_on;
		logic aux_relay_on;
		logic [3:0] notification_circuit;
		logic mute_led;
		logic aux_inhibit_led;
		logic circuits_inhibited_indicator;
		logic circuit_inhibit_led;
		logic disabled_list_led;
		logic trouble_list_led;
		logic ack_led;
		logic drill_led;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} pic_state_s;
endpackage

//--- hw/pic_panel_control.sv
// Front-panel silence, inhibit and drill control with APB registers
// What this block does
// - Each mute key press inverts the mute flag, which silences the sounder and lights the muted indicator.
// - A mute key press while muted clears the flag, restores the sounder and darkens the muted indicator.
// - A mute still in force 24 hours after an alarm or trouble is cleared automatically so the sounder resounds.
// - Each auxiliary-inhibit key press while the relay is off inverts the inhibit, which holds the relay off and lights its two indicators.
// - While the auxiliary relay is energised, auxiliary-inhibit key presses are ignored.
// - An auxiliary-inhibit press while inhibited lets the relay act again and darkens its two indicators.
// - Each circuit-inhibit key press inverts one flag that blocks all four circuits and lights four indicators.
// - While the circuits are inhibited the acknowledge indicator flashes.
// - A circuit-inhibit press while inhibited re-enables the circuits and darkens four indicators.
// - Each drill key press while the circuits are not inhibited toggles a manual evacuation on or off.
// - While the circuits are inhibited, drill key presses are ignored.
// - The drill indicator is lit exactly while a drill is active.
// - The disabled-list indicator is lit whenever any inhibit is in force.
//
// Chosen here: the APB slave port and the placing of the registers.
`timescale 1ns/100ps
`include "pic_params.svh"

module pic_panel_control
	import pic_pkg::*;
#(
	parameter int unsigned DEBOUNCE_CYCLES = `PIC_DEBOUNCE_CYCLES,
	parameter int unsigned TICK_CYCLES = `PIC_TICK_CYCLES,
	parameter int unsigned RESOUND_TICKS = `PIC_RESOUND_TICKS
) (
	input wire logic clock,
	input wire logic srst,
	input wire logic [3:0] keys,
	input wire logic alarm_event,
	input wire logic trouble_event,
	input wire logic trouble_present,
	input wire logic other_disable,
	input wire logic ack_request,
	input wire logic sounder_request,
	input wire logic aux_request,
	input wire logic [3:0] circuit_request,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq,
	output logic sounder_on,
	output logic aux_relay_on,
	output logic [3:0] notification_circuit,
	output logic mute_led,
	output logic aux_inhibit_led,
	output logic circuits_inhibited_indicator,
	output logic circuit_inhibit_led,
	output logic disabled_list_led,
	output logic trouble_list_led,
	output logic ack_led,
	output logic drill_led
);

	localparam pic_deb_t DEB_LIM = pic_deb_t'(DEBOUNCE_CYCLES - 1);
	localparam pic_tick_t TICK_LIM = pic_tick_t'(TICK_CYCLES - 1);
	localparam pic_hold_t HOLD_LIM = pic_hold_t'(RESOUND_TICKS - 1);

	pic_state_s r;
	pic_state_s next_r;

	function automatic logic addr_mapped(input logic [7:0] a);
		addr_mapped = (a == `PIC_ADDR_CTRL) || (a == `PIC_ADDR_STATUS) ||
			(a == `PIC_ADDR_INT_STATUS) || (a == `PIC_ADDR_INT_MASK);
	endfunction

	always_comb begin
		logic [3:0] press;
		logic [3:0] ev;
		logic [3:0] clr;
		logic tick;
		logic expire;
		logic wr;
		press = 4'h0;
		ev = 4'h0;
		clr = 4'h0;
		tick = 1'b0;
		expire = 1'b0;
		wr = psel && penable && pwrite && r.pready;
		next_r = r;

		// Three-stage synchroniser, then a stable-time debounce per key
		next_r.sync1 = keys;
		next_r.sync2 = r.sync1;
		next_r.sync3 = r.sync2;
		for (int i = 0; i < 4; i++) begin
			if (r.sync2[i] == r.sync3[i] && r.sync3[i] != r.key_level[i]) begin
				if (r.deb_cnt[i] >= DEB_LIM) begin
					next_r.key_level[i] = r.sync3[i];
					next_r.deb_cnt[i] = 20'h00000;
					press[i] = r.sync3[i] & r.keys_en;
				end else begin
					next_r.deb_cnt[i] = r.deb_cnt[i] + 20'h00001;
				end
			end else begin
				next_r.deb_cnt[i] = 20'h00000;
			end
		end

		// One-second time base
		if (r.tick_cnt >= TICK_LIM) begin
			next_r.tick_cnt = 27'h0000000;
			tick = 1'b1;
			next_r.flash = ~r.flash;
		end else begin
			next_r.tick_cnt = r.tick_cnt + 27'h0000001;
		end

		// Resound timer restarts at every alarm or trouble
		if (alarm_event || trouble_event) begin
			next_r.timer_armed = 1'b1;
			next_r.hold_cnt = 17'h00000;
			ev[`PIC_EV_TIMER_START] = 1'b1;
		end else if (r.timer_armed && tick) begin
			if (r.hold_cnt >= HOLD_LIM) begin
				next_r.timer_armed = 1'b0;
				expire = 1'b1;
			end else begin
				next_r.hold_cnt = r.hold_cnt + 17'h00001;
			end
		end

		if (press[`PIC_KEY_MUTE]) begin
			next_r.mute = ~r.mute;
		end else if (expire && r.mute) begin
			next_r.mute = 1'b0;
			ev[`PIC_EV_RESOUND] = 1'b1;
		end

		if (press[`PIC_KEY_AUX]) begin
			if (r.aux_relay_on) begin
				ev[`PIC_EV_AUX_IGNORED] = 1'b1;
			end else begin
				next_r.aux_inh = ~r.aux_inh;
			end
		end

		if (press[`PIC_KEY_NAC]) begin
			next_r.nac_inh = ~r.nac_inh;
		end

		if (press[`PIC_KEY_DRILL]) begin
			if (r.nac_inh) begin
				ev[`PIC_EV_DRILL_IGNORED] = 1'b1;
			end else begin
				next_r.drill = ~r.drill;
			end
		end

		// Registered outputs follow the new flags
		next_r.sounder_on = sounder_request & ~next_r.mute;
		next_r.mute_led = next_r.mute;
		next_r.aux_relay_on = aux_request & ~next_r.aux_inh;
		next_r.aux_inhibit_led = next_r.aux_inh;
		next_r.notification_circuit = (circuit_request | {4{next_r.drill}}) & ~{4{next_r.nac_inh}};
		next_r.circuits_inhibited_indicator = next_r.nac_inh;
		next_r.circuit_inhibit_led = next_r.nac_inh;
		next_r.trouble_list_led = trouble_present | next_r.nac_inh;
		next_r.disabled_list_led = next_r.aux_inh | next_r.nac_inh | other_disable;
		next_r.ack_led = next_r.nac_inh ? next_r.flash : ack_request;
		next_r.drill_led = next_r.drill;

		// APB slave: one wait state, write lands on the completing edge
		if (wr && paddr == `PIC_ADDR_CTRL) begin
			next_r.keys_en = pwdata[`PIC_CTRL_KEYS_EN_BIT];
		end else if (wr && paddr == `PIC_ADDR_INT_STATUS) begin
			clr = pwdata[3:0];
		end else if (wr && paddr == `PIC_ADDR_INT_MASK) begin
			next_r.int_mask = pwdata[3:0];
		end
		// A new event outweighs a clear in the same cycle
		next_r.int_status = (r.int_status & ~clr) | ev;
		next_r.irq = |(next_r.int_status & next_r.int_mask);

		next_r.pready = 1'b0;
		next_r.pslverr = 1'b0;
		next_r.prdata = 32'h00000000;
		// Read data stands only with pready; unmapped offsets read as zero
		if (psel && penable && !r.pready) begin
			next_r.pready = 1'b1;
			next_r.pslverr = ~addr_mapped(paddr);
			if (!pwrite && paddr == `PIC_ADDR_CTRL) begin
				next_r.prdata[`PIC_CTRL_KEYS_EN_BIT] = r.keys_en;
			end else if (!pwrite && paddr == `PIC_ADDR_STATUS) begin
				next_r.prdata[`PIC_ST_MUTE] = r.mute;
				next_r.prdata[`PIC_ST_AUX_INH] = r.aux_inh;
				next_r.prdata[`PIC_ST_NAC_INH] = r.nac_inh;
				next_r.prdata[`PIC_ST_DRILL] = r.drill;
				next_r.prdata[`PIC_ST_TIMER] = r.timer_armed;
			end else if (!pwrite && paddr == `PIC_ADDR_INT_STATUS) begin
				next_r.prdata[3:0] = r.int_status;
			end else if (!pwrite && paddr == `PIC_ADDR_INT_MASK) begin
				next_r.prdata[3:0] = r.int_mask;
			end
		end
	end

	// Keys start enabled and every interrupt starts masked
	always_ff @(posedge clock) begin
		if (srst) begin
			r <= '0;
			r.keys_en <= `PIC_CTRL_RESET;
			r.int_mask <= `PIC_INT_MASK_RESET;
		end else begin
			r <= next_r;
		end
	end

	assign prdata = r.prdata;
	assign pready = r.pready;
	assign pslverr = r.pslverr;
	assign irq = r.irq;
	assign sounder_on = r.sounder_on;
	assign aux_relay_on = r.aux_relay_on;
	assign notification_circuit = r.notification_circuit;
	assign mute_led = r.mute_led;
	assign aux_inhibit_led = r.aux_inhibit_led;
	assign circuits_inhibited_indicator = r.circuits_inhibited_indicator;
	assign circuit_inhibit_led = r.circuit_inhibit_led;
	assign disabled_list_led = r.disabled_list_led;
	assign trouble_list_led = r.trouble_list_led;
	assign ack_led = r.ack_led;
	assign drill_led = r.drill_led;

	default clocking cb @(posedge clock); endclocking
	default disable iff (srst);

	// Outputs are registered with their flags; holds are compared in the same cycle, releases one cycle later
	chk_mute_silences: assert property (r.mute |-> !sounder_on && mute_led)
		else $error("sounder sounds while muted");
	chk_mute_restores: assert property ($fell(r.mute) && sounder_request |=> sounder_on && !mute_led)
		else $error("sounder not restored after unmute");
	chk_resound_timer: assert property ($fell(r.timer_armed) && $past(r.mute)
		|-> !r.mute)
		else $error("mute survived resound timeout");
	chk_aux_held_off: assert property (r.aux_inh |-> !aux_relay_on && aux_inhibit_led && disabled_list_led)
		else $error("aux relay active while inhibited");
	chk_aux_key_ignored: assert property (aux_relay_on |=> $stable(r.aux_inh))
		else $error("aux inhibit changed while relay energised");
	chk_aux_release: assert property ($fell(r.aux_inh) |=> !aux_inhibit_led)
		else $error("aux inhibit indicator stayed lit");
	chk_circuits_blocked: assert property (r.nac_inh |-> notification_circuit == 4'h0
		&& circuits_inhibited_indicator && circuit_inhibit_led && disabled_list_led)
		else $error("circuit active while inhibited");
	chk_ack_flash: assert property (r.nac_inh && $past(r.nac_inh) && $changed(r.flash) |-> $changed(ack_led))
		else $error("acknowledge indicator not flashing");
	chk_circuits_release: assert property ($fell(r.nac_inh) && !trouble_present |=> !trouble_list_led
		&& !circuit_inhibit_led)
		else $error("circuit inhibit indicators stayed lit");
	chk_drill_locked: assert property (r.nac_inh |=> $stable(r.drill))
		else $error("drill changed while circuits inhibited");
	chk_drill_led: assert property ($changed(r.drill) |-> drill_led == r.drill)
		else $error("drill indicator wrong");
	chk_one_toggle: assert property ($changed(r.nac_inh) |=> $stable(r.nac_inh) [*2])
		else $error("inhibit toggled twice in a row");

	// Each debounced press acts once, and only while keys are enabled
	chk_mute_key_toggle: assert property ($rose(r.key_level[`PIC_KEY_MUTE]) && $past(r.keys_en)
		|-> $changed(r.mute))
		else $error("mute key press did not toggle mute");
	chk_aux_key_toggle: assert property ($rose(r.key_level[`PIC_KEY_AUX]) && $past(r.keys_en)
		&& !$past(r.aux_relay_on) |-> $changed(r.aux_inh))
		else $error("aux key press did not toggle inhibit");
	chk_aux_ignore_flag: assert property ($rose(r.key_level[`PIC_KEY_AUX]) && $past(r.keys_en)
		&& $past(r.aux_relay_on) |-> r.int_status[`PIC_EV_AUX_IGNORED])
		else $error("ignored aux press not flagged");
	chk_circuit_key_toggle: assert property ($rose(r.key_level[`PIC_KEY_NAC]) && $past(r.keys_en)
		|-> $changed(r.nac_inh))
		else $error("circuit key press did not toggle inhibit");
	chk_drill_key_toggle: assert property ($rose(r.key_level[`PIC_KEY_DRILL]) && $past(r.keys_en)
		&& !$past(r.nac_inh) |-> $changed(r.drill))
		else $error("drill key press did not toggle drill");
	chk_drill_ignore_flag: assert property ($rose(r.key_level[`PIC_KEY_DRILL]) && $past(r.keys_en)
		&& $past(r.nac_inh) |-> r.int_status[`PIC_EV_DRILL_IGNORED])
		else $error("ignored drill press not flagged");
	chk_keys_locked: assert property (!$past(r.keys_en) |-> $stable({r.aux_inh, r.nac_inh, r.drill}))
		else $error("flag toggled while keys disabled");

	// Level indicators and circuit outputs track their sources one cycle later
	chk_disabled_list: assert property (!$past(srst)
		|-> disabled_list_led == (r.aux_inh || r.nac_inh || $past(other_disable)))
		else $error("disabled list indicator wrong");
	chk_trouble_list: assert property (!$past(srst)
		|-> trouble_list_led == (r.nac_inh || $past(trouble_present)))
		else $error("trouble list indicator wrong");
	chk_ack_steady: assert property (!$past(srst) && !r.nac_inh
		|-> ack_led == $past(ack_request))
		else $error("acknowledge indicator not steady");
	chk_timer_restart: assert property (!$past(srst) && $past(alarm_event || trouble_event)
		|-> r.timer_armed && r.hold_cnt == 17'h00000)
		else $error("resound timer not restarted");
	chk_drill_drives: assert property (r.drill && !r.nac_inh |-> notification_circuit == 4'hF)
		else $error("drill does not drive every circuit");
	chk_circuits_enabled: assert property (!$past(srst) && !r.nac_inh
		|-> notification_circuit == ($past(circuit_request) | {4{r.drill}}))
		else $error("enabled circuit does not follow its request");

endmodule

//--- testbench/pic_keypad_model.sv
// Keypad model: one clean press and release of a chosen key per request
`timescale 1ns/100ps
module pic_keypad_model (
	input wire logic clock,
	input wire logic srst,
	input wire logic req,
	input wire logic [1:0] sel,
	output logic [3:0] keys,
	output logic busy
);
	logic [4:0] cnt;
	logic [1:0] idx;
	assign busy = cnt != 5'h00;
	// Press and release each outlast the debouncer
	assign keys = (busy && cnt > 5'h0D) ? 4'h1 << idx : 4'h0;
	always_ff @(posedge clock) begin
		if (srst) begin
			cnt <= 5'h00;
			idx <= 2'h0;
		end else if (busy) begin
			cnt <= cnt - 5'h01;
		end else if (req) begin
			cnt <= 5'h1A;
			idx <= sel;
		end
	end
endmodule

//--- testbench/panel_inhibit_silence_control_tb_top.sv
// Testbench for the panel inhibit and silence control block
`timescale 1ns/100ps
module panel_inhibit_silence_control_tb_top;
	logic clock = 1'b0;
	logic srst = 1'b1;
	logic [3:0] keys;
	logic alarm_event = 1'b0;
	logic trouble_event = 1'b0;
	logic trouble_present = 1'b0;
	logic other_disable = 1'b0;
	logic ack_request = 1'b0;
	logic sounder_request = 1'b0;
	logic aux_request = 1'b0;
	logic [3:0] circuit_request = 4'h0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr, irq, sounder_on, aux_relay_on, mute_led, aux_inhibit_led;
	logic cii, cil, dll, tll, ack_led, drill_led, req = 1'b0, busy;
	logic [3:0] nc;
	logic [1:0] sel = 2'h0;
	int num_errors = 0;
	int n_checks = 0;
	pic_panel_control #(.DEBOUNCE_CYCLES(4), .TICK_CYCLES(10), .RESOUND_TICKS(3)) pic_panel_control_i (
		.clock(clock), .srst(srst), .keys(keys), .alarm_event(alarm_event), .trouble_event(trouble_event),
		.trouble_present(trouble_present), .other_disable(other_disable), .ack_request(ack_request),
		.sounder_request(sounder_request), .aux_request(aux_request), .circuit_request(circuit_request),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .irq(irq), .sounder_on(sounder_on), .aux_relay_on(aux_relay_on),
		.notification_circuit(nc), .mute_led(mute_led), .aux_inhibit_led(aux_inhibit_led),
		.circuits_inhibited_indicator(cii), .circuit_inhibit_led(cil), .disabled_list_led(dll),
		.trouble_list_led(tll), .ack_led(ack_led), .drill_led(drill_led));
	pic_keypad_model pic_keypad_model_i (.clock(clock), .srst(srst), .req(req), .sel(sel), .keys(keys), .busy(busy));
	initial begin
		forever #5 clock = ~clock;
	end
	task automatic end_sim();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: %s got %0h expected %0h", $time, msg, got, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd,
		output logic err);
		int n;
		n = 0;
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clock);
		penable <= 1'b1;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		chk(pready, 1, "apb ready");
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] rd;
		logic e;
		apb(1'b1, a, d, rd, e);
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input logic eexp);
		logic [31:0] rd;
		logic e;
		apb(1'b0, a, 32'h0, rd, e);
		chk(rd, exp, "read data");
		chk(e, eexp, "slave error");
	endtask
	task automatic press(input logic [1:0] k);
		int n;
		n = 0;
		@(posedge clock);
		req <= 1'b1;
		sel <= k;
		@(posedge clock);
		req <= 1'b0;
		do begin
			@(posedge clock);
			n++;
		end while (busy && n < 40);
		repeat (2) @(posedge clock);
	endtask
	task automatic t_reset();
		chk({mute_led, aux_inhibit_led, cii, cil, dll, drill_led, nc, irq}, 0, "reset outputs");
		rdchk(8'h00, 32'h1, 1'b0);
		rdchk(8'h0C, 32'h0, 1'b0);
		wr(8'h10, 32'hF);
		rdchk(8'h10, 32'h0, 1'b1);
	endtask
	task automatic t_mute();
		sounder_request <= 1'b1;
		press(2'h0);
		chk({mute_led, sounder_on}, 2'b10, "muted");
		rdchk(8'h04, 32'h1, 1'b0);
		press(2'h0);
		chk({mute_led, sounder_on}, 2'b01, "unmuted");
	endtask
	task automatic t_resound();
		for (int i = 0; i < 2; i++) begin
			press(2'h0);
			alarm_event <= i == 0;
			trouble_event <= i == 1;
			@(posedge clock);
			alarm_event <= 1'b0;
			trouble_event <= 1'b0;
			repeat (15) @(posedge clock);
			chk(mute_led, 1, "still muted");
			repeat (30) @(posedge clock);
			chk({mute_led, sounder_on}, 2'b01, "resounded");
		end
		rdchk(8'h08, 32'h9, 1'b0);
		wr(8'h0C, 32'h1);
		repeat (3) @(posedge clock);
		chk(irq, 1, "irq raised");
		wr(8'h08, 32'h1);
		repeat (3) @(posedge clock);
		chk(irq, 0, "irq cleared");
		wr(8'h08, 32'hF);
	endtask
	task automatic t_aux();
		press(2'h1);
		aux_request <= 1'b1;
		repeat (2) @(posedge clock);
		chk({aux_relay_on, aux_inhibit_led, dll}, 3'b011, "aux inhibited");
		press(2'h1);
		chk({aux_relay_on, aux_inhibit_led, dll}, 3'b100, "aux enabled");
		press(2'h1);
		chk({aux_relay_on, aux_inhibit_led, dll}, 3'b100, "aux press ignored");
		rdchk(8'h08, 32'h2, 1'b0);
		wr(8'h08, 32'hF);
		aux_request <= 1'b0;
	endtask
	task automatic t_circuits();
		logic f;
		logic g;
		f = 1'b0;
		g = 1'b0;
		circuit_request <= 4'hF;
		press(2'h2);
		chk({nc, cii, cil, dll, tll}, 8'h0F, "circuits inhibited");
		repeat (25) begin
			@(posedge clock);
			f = f | ack_led;
			g = g | !ack_led;
		end
		chk({f, g}, 2'b11, "ack flashing");
		press(2'h3);
		chk(drill_led, 0, "drill ignored");
		rdchk(8'h08, 32'h4, 1'b0);
		wr(8'h08, 32'hF);
		press(2'h2);
		chk({nc, cii, cil, dll, tll}, 8'hF0, "circuits enabled");
		circuit_request <= 4'h0;
	endtask
	task automatic t_drill();
		press(2'h3);
		chk({drill_led, nc}, 5'h1F, "drill on");
		press(2'h3);
		chk({drill_led, nc}, 5'h00, "drill off");
	endtask
	task automatic t_lock();
		wr(8'h00, 32'h0);
		rdchk(8'h00, 32'h0, 1'b0);
		press(2'h3);
		chk(drill_led, 0, "key ignored while disabled");
		wr(8'h00, 32'h1);
		other_disable <= 1'b1;
		trouble_present <= 1'b1;
		ack_request <= 1'b1;
		repeat (3) @(posedge clock);
		chk({dll, tll, ack_led}, 3'b111, "list and ack levels");
		other_disable <= 1'b0;
		trouble_present <= 1'b0;
		ack_request <= 1'b0;
		repeat (3) @(posedge clock);
		chk({dll, tll, ack_led}, 3'b000, "list and ack cleared");
	endtask
	initial begin
		repeat (20000) @(posedge clock);
		num_errors++;
		end_sim();
	end
	initial begin
		repeat (20) @(posedge clock);
		srst <= 1'b0;
		repeat (3) @(posedge clock);
		t_reset();
		t_mute();
		t_resound();
		t_aux();
		t_circuits();
		t_drill();
		t_lock();
		end_sim();
	end
endmodule
